// >>> sdct_pkg.sv
package sdct_pkg;
  // Command pin pattern {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACTIVE  = 4'h3;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_STOP    = 4'h6;
  localparam logic [3:0] CMD_PRECHG  = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LMR     = 4'h0;
  // Fixed clock figures
  localparam int DQZ_CYCLES   = 2;
  localparam int CKED_CYCLES  = 1;
  localparam int PED_CYCLES   = 1;
  localparam int WR_CYCLES    = 1;
  localparam int WR_EXTRA_NS  = 7;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WR_EXTRA_CYC = (WR_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CL_RESET = 2'h3;
  localparam logic [1:0] BURST_RESET = 2'h0;
  // Command bundle
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [1:0] bank;
    logic [12:0] addr;
  } sdct_cmd_t;
  typedef enum {ST_IDLE, ST_READ, ST_WRITE} sdct_state_t;
endpackage

// >>> sdct_core.sv
module sdct_core import sdct_pkg::*; #(
  parameter int DW = 16,
  parameter int CW = 9
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // Command side
  input  wire logic          cke_in,
  input  wire sdct_cmd_t     cmd_in,
  input  wire logic          dqm_in,
  // Data side
  input  wire logic [DW-1:0] dq_in,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe_out,
  // Internal array port
  output logic               wr_en_out,
  output logic [CW-1:0]      wr_col_out,
  output logic [DW-1:0]      wr_data_out,
  input  wire logic [DW-1:0] rd_data_in,
  output logic [CW-1:0]      rd_col_out,
  // Status
  output logic               clk_active_out,
  output logic               self_refresh_out,
  output logic               ap_start_out
);
  // Mode and burst bookkeeping
  sdct_state_t  state, next_state;
  logic [1:0]   cl, next_cl;             // Read latency
  logic [1:0]   blen, next_blen;         // Burst length code
  logic [7:0]   left, next_left;         // Words left in burst
  logic [CW-1:0] col, next_col;          // Running column
  logic         ap, next_ap;             // Auto precharge armed
  logic         clk_act, next_clk_act;   // Internal clock running
  logic         sref, next_sref;         // Self refresh
  logic [1:0]   wrrec, next_wrrec;       // Write recovery count
  logic         ap_pulse, next_ap_pulse;
  // Read pipeline, deep enough for longest latency
  logic [3:0]   rd_v, next_rd_v;
  logic [3:0]   msk, next_msk;           // Mask sampled per cycle
  logic [DW-1:0] dq, next_dq;
  logic [3:0][DW-1:0] rd_d, next_rd_d;   // Read words, staged like rd_v
  logic         oe, next_oe;

  // Command decode, used for several checks
  function automatic logic is_cmd(input sdct_cmd_t c, input logic [3:0] k);
    return {c.cs_n, c.ras_n, c.cas_n, c.we_n} == k;
  endfunction

  function automatic logic [7:0] blen_words(input logic [1:0] b);
    return 8'(1) << b;
  endfunction

  logic go;
  assign go = clk_act;

  // Next values for all control state
  always_comb begin
    next_state = state;
    next_cl = cl;
    next_blen = blen;
    next_left = left;
    next_col = col;
    next_ap = ap;
    next_sref = sref;
    next_wrrec = wrrec;
    next_ap_pulse = 1'b0;
    next_rd_v = {rd_v[2:0], 1'b0};
    next_msk = {msk[2:0], dqm_in};
    wr_en_out = 1'b0;
    wr_col_out = col;
    wr_data_out = dq_in;
    rd_col_out = col;
    // Clock enable acts one clock after it is sampled
    next_clk_act = cke_in;
    if (!go) begin
      // Suspended: hold everything, mask history frozen too
      next_rd_v = rd_v;
      next_msk = msk;
    end else begin
      if (wrrec != 2'h0) begin
        next_wrrec = wrrec - 2'h1;
        if (wrrec == 2'h1) begin
          next_ap_pulse = 1'b1;
        end
      end
      if (state == ST_WRITE) begin
        // Later words of a write burst, mask on same edge
        wr_en_out = !dqm_in;
        next_col = col + CW'(1);
        next_left = left - 8'h1;
        if (left == 8'h1) begin
          next_state = ST_IDLE;
          if (ap) next_wrrec = 2'(WR_CYCLES + WR_EXTRA_CYC);
        end
      end else if (state == ST_READ) begin
        next_rd_v[0] = 1'b1;
        next_col = col + CW'(1);
        next_left = left - 8'h1;
        if (left == 8'h1) next_state = ST_IDLE;
      end
      // New command overrides burst in progress
      if (is_cmd(cmd_in, CMD_READ) || is_cmd(cmd_in, CMD_WRITE)) begin
        next_ap = cmd_in.addr[10];
        next_left = blen_words(blen) - 8'h1;
        next_col = cmd_in.addr[CW-1:0] + CW'(1);
        if (is_cmd(cmd_in, CMD_WRITE)) begin
          wr_en_out = !dqm_in;
          wr_col_out = cmd_in.addr[CW-1:0];
          next_state = (blen == 2'h0) ? ST_IDLE : ST_WRITE;
          if (blen == 2'h0 && cmd_in.addr[10])
            next_wrrec = 2'(WR_CYCLES + WR_EXTRA_CYC);
        end else begin
          rd_col_out = cmd_in.addr[CW-1:0];
          next_rd_v[0] = 1'b1;
          next_state = (blen == 2'h0) ? ST_IDLE : ST_READ;
        end
      end else if (is_cmd(cmd_in, CMD_STOP)) begin
        next_state = ST_IDLE;
      end else if (is_cmd(cmd_in, CMD_PRECHG)) begin
        // Read cut short; queued words drain over latency
        if (state == ST_READ) next_state = ST_IDLE;
        if (state == ST_READ) next_rd_v[0] = 1'b0;
      end else if (is_cmd(cmd_in, CMD_LMR)) begin
        next_cl = cmd_in.addr[5:4];
        next_blen = cmd_in.addr[1:0];
      end
    end
    // Refresh encoding with clock enable falling enters self refresh
    if (is_cmd(cmd_in, CMD_REFRESH) && !cke_in && clk_act)
      next_sref = 1'b1;
    else if (sref && cke_in)
      next_sref = 1'b0;
  end

  // Output stage: word leaves after latency, mask two clocks back
  always_comb begin
    next_dq = dq;
    next_oe = oe;
    next_rd_d = rd_d;
    if (go) begin
      // Word fetched in its column cycle, delayed beside its valid bit
      next_rd_d = {rd_d[2:0], rd_data_in};
      next_dq = rd_d[cl - 2'h1];
      next_oe = rd_v[cl - 2'h1] && !msk[DQZ_CYCLES - 1];
    end
  end

  // Register everything
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      cl <= CL_RESET;
      blen <= BURST_RESET;
      left <= 8'h00;
      col <= '0;
      ap <= 1'b0;
      clk_act <= 1'b1;
      sref <= 1'b0;
      wrrec <= 2'h0;
      ap_pulse <= 1'b0;
      rd_v <= 4'h0;
      msk <= 4'hF;
      dq <= '0;
      rd_d <= '0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      cl <= next_cl;
      blen <= next_blen;
      left <= next_left;
      col <= next_col;
      ap <= next_ap;
      clk_act <= next_clk_act;
      sref <= next_sref;
      wrrec <= next_wrrec;
      ap_pulse <= next_ap_pulse;
      rd_v <= next_rd_v;
      msk <= next_msk;
      dq <= next_dq;
      rd_d <= next_rd_d;
      oe <= next_oe;
    end
  end

  assign dq_out = dq;
  assign dq_oe_out = oe;
  assign clk_active_out = clk_act;
  assign self_refresh_out = sref;
  assign ap_start_out = ap_pulse;

  // Checks
  property p_cke_lag;
    @(posedge clk_in) disable iff (!rst_n_in) 1'b1 |=> (clk_act == $past(cke_in));
  endproperty
  a_cke_lag: assert property (p_cke_lag) else $error("clock enable lag wrong");
  property p_cke_resume;
    @(posedge clk_in) disable iff (!rst_n_in) (!clk_act && cke_in) |=> clk_act;
  endproperty
  a_cke_resume: assert property (p_cke_resume) else $error("clock not resumed");
  property p_wmask;
    @(posedge clk_in) disable iff (!rst_n_in) (go && dqm_in) |-> !wr_en_out;
  endproperty
  a_wmask: assert property (p_wmask) else $error("masked word written");
  property p_first_word;
    @(posedge clk_in) disable iff (!rst_n_in)
      (go && is_cmd(cmd_in, CMD_WRITE) && !dqm_in) |-> (wr_en_out && wr_data_out == dq_in);
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word missed");
  property p_rmask;
    @(posedge clk_in) disable iff (!rst_n_in)
      (dqm_in && clk_act) ##1 clk_act ##1 clk_act |=> !oe;
  endproperty
  a_rmask: assert property (p_rmask) else $error("mask did not float");
  property p_back2back;
    @(posedge clk_in) disable iff (!rst_n_in)
      (go && is_cmd(cmd_in, CMD_READ)) |=> (state == ST_READ || blen == 2'h0);
  endproperty
  a_back2back: assert property (p_back2back) else $error("column command dropped");
  property p_sref;
    @(posedge clk_in) disable iff (!rst_n_in)
      (is_cmd(cmd_in, CMD_REFRESH) && !cke_in && clk_act) |=> sref;
  endproperty
  a_sref: assert property (p_sref) else $error("self refresh not entered");
  property p_ap;
    @(posedge clk_in) disable iff (!rst_n_in) ap_pulse |-> $past(wrrec) == 2'h1;
  endproperty
  a_ap: assert property (p_ap) else $error("precharge start wrong");
  property p_pre_cut;
    @(posedge clk_in) disable iff (!rst_n_in)
      (go && state == ST_READ && is_cmd(cmd_in, CMD_PRECHG)) |=> state == ST_IDLE;
  endproperty
  a_pre_cut: assert property (p_pre_cut) else $error("read not cut");
endmodule

// >>> sdct_ctl_model.sv
module sdct_ctl_model import sdct_pkg::*; (
  // Clock from the bench
  input  wire logic   clk_in,
  // Pins toward the device
  output logic        cke_out,
  output sdct_cmd_t   cmd_out,
  output logic        dqm_out,
  output logic [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Power-up state: deselected, clock enabled
  initial begin
    cke_out = 1'b1;
    cmd_out = {4'hF, 2'h0, 13'h0000};
    dqm_out = 1'b0;
    dq_out  = 16'h5A5A;
  end
  // One command per falling edge, held over one rising edge; callers space
  // mode commands; column, stop, precharge and activate commands may go back to back
  task automatic put(input logic [3:0] c, input logic [12:0] a, input logic m,
                     input logic [15:0] d, input logic k);
    @(negedge clk_in);
    cmd_out = {c, 2'h0, a};
    dqm_out = m;
    // Data only with WRITE; otherwise the released bus keeps moving
    dq_out  = (c == CMD_WRITE) ? d : ~dq_out;
    cke_out = k;
  endtask
endmodule

// >>> tb_top.sv
module tb_top import sdct_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] NOP = 4'h7;
  // Device pins
  logic        clk_in, rst_n_in, cke_in, dqm_in, dq_oe_out, wr_en_out;
  logic        clk_active_out, self_refresh_out, ap_start_out;
  sdct_cmd_t   cmd_in;
  logic [15:0] dq_in, dq_out, wr_data_out, rd_data_in;
  logic [8:0]  wr_col_out, rd_col_out;
  // Bookkeeping
  int          miscompares, n_checks, hits;
  // Array model: word tagged with its own column
  assign rd_data_in = {7'h52, rd_col_out};
  sdct_ctl_model ctl_inst (.clk_in(clk_in), .cke_out(cke_in), .cmd_out(cmd_in),
                           .dqm_out(dqm_in), .dq_out(dq_in));
  sdct_core sdct_core_inst (.clk_in, .rst_n_in, .cke_in, .cmd_in, .dqm_in, .dq_in,
    .dq_out, .dq_oe_out, .wr_en_out, .wr_col_out, .wr_data_out, .rd_data_in,
    .rd_col_out, .clk_active_out, .self_refresh_out, .ap_start_out);
  // Fixed-rate clock, never stretched
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic op(input logic [3:0] c, input logic [12:0] a);
    ctl_inst.put(c, a, 1'b0, 16'h0000, 1'b1);
  endtask
  // Mode load then three idle clocks before anything else
  task automatic lmr(input logic [12:0] a);
    op(CMD_LMR, a);
    repeat (3) op(NOP, 13'h0000);
  endtask
  // Single read; mask raised one clock after the command
  task automatic rd(input logic [8:0] col, input int cl, input logic m);
    op(CMD_READ, {4'h0, col});
    ctl_inst.put(NOP, 13'h0000, m, 16'h0000, 1'b1);
    op(NOP, 13'h0000);
    repeat (cl - 2) @(negedge clk_in);
    chk("oe early", 16'h0000, {15'h0000, dq_oe_out});
    @(negedge clk_in);
    chk("oe", {15'h0000, ~m}, {15'h0000, dq_oe_out});
    if (!m) chk("dq", {7'h52, col}, dq_out);
    repeat (4) op(NOP, 13'h0000);
  endtask
  // Write word checked while the command is still on the pins
  task automatic wr(input logic [12:0] a, input logic m, input logic [15:0] d);
    ctl_inst.put(CMD_WRITE, a, m, d, 1'b1);
    #1;
    chk("wr_en", {15'h0000, ~m}, {15'h0000, wr_en_out});
    if (!m) chk("wr_data", d, wr_data_out);
    if (!m) chk("wr_col", {7'h00, a[8:0]}, {7'h00, wr_col_out});
  endtask
  task automatic t_read();
    rd(9'h005, 3, 1'b0);
    rd(9'h006, 3, 1'b1);
    lmr(13'h0020);
    rd(9'h007, 2, 1'b0);
    $display("test read done");
  endtask
  task automatic t_write();
    wr(13'h0010, 1'b0, 16'h1234);
    wr(13'h0011, 1'b1, 16'h5678);
    wr(13'h0012, 1'b0, 16'h9ABC);
    wr(13'h0413, 1'b0, 16'hDEF0);
    hits = 0;
    repeat (6) begin
      op(NOP, 13'h0000);
      if (ap_start_out === 1'b1) hits++;
    end
    chk("ap_start", 16'h0001, hits[15:0]);
    op(CMD_ACTIVE, 13'h0000);
    $display("test write done");
  endtask
  // Precharge one clock into a four-word read cuts it
  task automatic t_prech();
    lmr(13'h0022);
    op(CMD_READ, 13'h0020);
    op(CMD_PRECHG, 13'h0000);
    op(NOP, 13'h0000);
    @(negedge clk_in);
    chk("oe pre", 16'h0001, {15'h0000, dq_oe_out});
    @(negedge clk_in);
    chk("oe cut", 16'h0000, {15'h0000, dq_oe_out});
    repeat (4) op(NOP, 13'h0000);
    lmr(13'h0020);
    $display("test precharge done");
  endtask
  // Four-word bursts at latency one; write burst cut by a stop
  task automatic t_burst();
    lmr(13'h0012);
    op(CMD_READ, 13'h0044);
    op(NOP, 13'h0000);
    for (int i = 0; i < 4; i++) begin
      op(NOP, 13'h0000);
      chk("burst oe", 16'h0001, {15'h0000, dq_oe_out});
      chk("burst dq", {7'h52, 9'h044 + 9'(i)}, dq_out);
    end
    op(NOP, 13'h0000);
    chk("burst end", 16'h0000, {15'h0000, dq_oe_out});
    wr(13'h0050, 1'b0, 16'h1111);
    ctl_inst.put(NOP, 13'h0000, 1'b0, 16'h0000, 1'b1);
    #1;
    // Model inverts the idle bus, so the second word is the complement
    chk("burst wr_en", 16'h0001, {15'h0000, wr_en_out});
    chk("burst wr_data", 16'hEEEE, wr_data_out);
    chk("burst wr_col", 16'h0051, {7'h00, wr_col_out});
    ctl_inst.put(CMD_STOP, 13'h0000, 1'b1, 16'h0000, 1'b1);
    #1;
    chk("stop mask", 16'h0000, {15'h0000, wr_en_out});
    ctl_inst.put(CMD_PRECHG, 13'h0000, 1'b0, 16'h0000, 1'b1);
    #1;
    chk("stop end", 16'h0000, {15'h0000, wr_en_out});
    op(NOP, 13'h0000);
    lmr(13'h0020);
    $display("test burst done");
  endtask
  // Suspended clock refuses a write
  task automatic t_cke();
    ctl_inst.put(NOP, 13'h0000, 1'b0, 16'h0000, 1'b0);
    ctl_inst.put(NOP, 13'h0000, 1'b0, 16'h0000, 1'b0);
    ctl_inst.put(CMD_WRITE, 13'h0031, 1'b0, 16'h4321, 1'b0);
    #1;
    chk("clk_active", 16'h0000, {15'h0000, clk_active_out});
    chk("wr_en off", 16'h0000, {15'h0000, wr_en_out});
    op(NOP, 13'h0000);
    repeat (3) @(negedge clk_in);
    chk("clk_active", 16'h0001, {15'h0000, clk_active_out});
    $display("test cke done");
  endtask
  task automatic t_sref();
    ctl_inst.put(CMD_REFRESH, 13'h0000, 1'b0, 16'h0000, 1'b0);
    ctl_inst.put(NOP, 13'h0000, 1'b0, 16'h0000, 1'b0);
    @(negedge clk_in);
    chk("sref in", 16'h0001, {15'h0000, self_refresh_out});
    repeat (4) op(NOP, 13'h0000);
    op(CMD_ACTIVE, 13'h0000);
    chk("sref out", 16'h0000, {15'h0000, self_refresh_out});
    op(CMD_REFRESH, 13'h0000);
    repeat (2) op(NOP, 13'h0000);
    chk("auto ref", 16'h0000, {15'h0000, self_refresh_out});
    $display("test self refresh done");
  endtask
  initial begin
    miscompares = 0;
    n_checks = 0;
    rst_n_in = 1'b0;
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    // Power-up pause then two wake refreshes
    repeat (2000) @(negedge clk_in);
    repeat (2) begin
      op(CMD_REFRESH, 13'h0000);
      repeat (2) op(NOP, 13'h0000);
    end
    t_read();
    t_write();
    t_prech();
    t_burst();
    t_cke();
    t_sref();
    close_out();
  end
  // Hang guard, well past the expected run
  initial begin
    #500000;
    miscompares++;
    close_out();
  end
endmodule
